// *** inc/diag_image_pkg.sv ***
// Package: constants, types and register map of the eight-channel input image block
// Overview of operation
// RL1 - Two input bytes, two output bytes, eight channels
// RL2 - Channel n state in first input byte bit n-1
// RL3 - Channel n fault in second input byte bit n-1
// RL4 - Controller writes zero to first output byte
// RL5 - Second output byte bit set switches channel off
// RL6 - Thermistor variant shares the same input layout
// RL7 - Lower byte is less significant in a word
// RL8 - Input bytes refresh every exchange cycle
package diag_image_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int CHANNELS = 8;              // Field input channels
  localparam int BYTE_W = 8;                // One image byte

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [31:0] INPUT_IMAGE_OFFSET = 32'h0000_0000;   // State and fault bytes
  localparam logic [31:0] OUTPUT_IMAGE_OFFSET = 32'h0000_0004;  // Reserved and switch-off bytes
  localparam logic [31:0] VARIANT_OFFSET = 32'h0000_0008;       // Sensor variant, read only

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int FIRST_BYTE_LSB = 0;        // first_image_byte position in a word
  localparam int SECOND_BYTE_LSB = 8;       // second_image_byte position in a word
  localparam logic [7:0] SWITCH_OFF_RESET = 8'h00;  // All channels on after reset
  localparam logic [7:0] RESERVED_BYTE_VALUE = 8'h00; // Reserved byte always reads zero
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;  // Unmapped read value

  // ----------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;  // Only htrans[1] is decoded
  localparam logic HRESP_OKAY = 1'h0;           // Always OKAY

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    VARIANT_PROXIMITY,
    VARIANT_THERMISTOR
  } variant_e;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_INPUT,
    SEL_OUTPUT,
    SEL_VARIANT
  } reg_sel_e;

  // Input image word, upper byte first
  typedef struct packed {
    logic [7:0] fault;   // second_image_byte
    logic [7:0] state;   // first_image_byte
  } input_image_s;

  // Latched data phase of one bus transfer
  typedef struct packed {
    logic valid;
    logic write;
    reg_sel_e sel;
  } data_phase_s;

endpackage

// *** src/channel_conditioner.sv ***
// Module: per-channel gating of field signal state and fault detection
`timescale 1ns/1ns
module channel_conditioner #(
  parameter int CHANNELS = 8
) (
  input wire logic [CHANNELS-1:0] raw_state,
  input wire logic [CHANNELS-1:0] wire_break,
  input wire logic [CHANNELS-1:0] short_circuit,
  input wire logic [CHANNELS-1:0] switch_off,
  output logic [CHANNELS-1:0] state,
  output logic [CHANNELS-1:0] fault
);

  // ----------------------------------------
  // One identical slice per channel
  // ----------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // Switched-off channel reports neither state nor fault; one driver per bit
      assign state[ch] = raw_state[ch] & ~switch_off[ch];                        // RL5
      assign fault[ch] = (wire_break[ch] | short_circuit[ch]) & ~switch_off[ch]; // RL3
    end
  endgenerate

endmodule

// *** src/octal_input_diag_image.sv ***
// Module: AHB-Lite slave exposing the eight-channel input and output image
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module octal_input_diag_image #(
  parameter diag_image_pkg::variant_e VARIANT = diag_image_pkg::VARIANT_PROXIMITY
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [diag_image_pkg::CHANNELS-1:0] channel_input_state,
  input wire logic [diag_image_pkg::CHANNELS-1:0] wire_break,
  input wire logic [diag_image_pkg::CHANNELS-1:0] short_circuit,
  output logic [diag_image_pkg::CHANNELS-1:0] channel_switch_off
);
  import diag_image_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Maps a byte address to a register; used for the address phase
  function automatic reg_sel_e decode(input logic [31:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == INPUT_IMAGE_OFFSET) begin
      sel = SEL_INPUT;
    end else if (addr == OUTPUT_IMAGE_OFFSET) begin
      sel = SEL_OUTPUT;
    end else if (addr == VARIANT_OFFSET) begin
      sel = SEL_VARIANT;
    end
    return sel;
  endfunction

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic [CHANNELS-1:0] cond_state;   // Gated channel states
  logic [CHANNELS-1:0] cond_fault;   // Gated channel faults
  input_image_s image_reg;           // Snapshot of the input image
  input_image_s image_next;
  logic [7:0] switch_off_reg;        // second_image_byte of output image
  logic [7:0] switch_off_next;
  data_phase_s dp_reg;               // Pending data phase
  data_phase_s dp_next;
  logic [31:0] hrdata_reg;           // Read data register
  logic [31:0] hrdata_next;
  logic addr_phase;                  // Transfer taken this edge

  // ----------------------------------------
  // Channel front end
  // ----------------------------------------
  channel_conditioner #(
    .CHANNELS(CHANNELS)
  ) u_cond (
    .raw_state(channel_input_state),
    .wire_break(wire_break),
    .short_circuit(short_circuit),
    .switch_off(switch_off_reg),
    .state(cond_state),
    .fault(cond_fault)
  );

  // ----------------------------------------
  // Input image refresh
  // ----------------------------------------
  // Every clock is one exchange cycle; both bytes refresh together
  always_comb begin
    image_next.state = cond_state;   // RL2
    image_next.fault = cond_fault;   // RL3 RL8
  end

  // Image snapshot register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      image_reg <= '0;
    end else begin
      image_reg <= image_next;
    end
  end

  // ----------------------------------------
  // Bus address and data phases
  // ----------------------------------------
  assign addr_phase = hsel & htrans[1] & hready;

  // Next data phase, write effects and read data
  always_comb begin
    dp_next = dp_reg;
    switch_off_next = switch_off_reg;
    hrdata_next = hrdata_reg;
    // Write lands in its data phase; reserved byte is dropped
    if (dp_reg.valid && dp_reg.write && dp_reg.sel == SEL_OUTPUT) begin
      switch_off_next = hwdata[SECOND_BYTE_LSB +: BYTE_W];  // RL5 RL1
    end
    if (hready) begin
      dp_next.valid = addr_phase;
      dp_next.write = hwrite;
      dp_next.sel = decode(haddr);
    end
    // Read data loaded at the address phase, forwarding a pending write
    if (addr_phase && !hwrite) begin
      unique case (decode(haddr))
        SEL_INPUT: begin
          hrdata_next = {16'h0000, image_reg};  // RL1 RL7 RL6
        end
        SEL_OUTPUT: begin
          hrdata_next = {16'h0000, switch_off_next, RESERVED_BYTE_VALUE};  // RL1 RL7
        end
        SEL_VARIANT: begin
          hrdata_next = {31'h0000_0000, VARIANT == VARIANT_THERMISTOR};  // RL6
        end
        SEL_NONE: begin
          hrdata_next = READ_ZERO;
        end
      endcase
    end
  end

  // Bus state registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_reg <= '0;
      switch_off_reg <= SWITCH_OFF_RESET;
      hrdata_reg <= READ_ZERO;
    end else begin
      dp_reg <= dp_next;
      switch_off_reg <= switch_off_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hreadyout = 1'b1;       // Zero wait states
  assign hresp = HRESP_OKAY;     // Never an error
  assign hrdata = hrdata_reg;
  assign channel_switch_off = switch_off_reg;  // RL5

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Helper: read of a given register taken this edge, or output write in its data phase
  logic rd_input;
  logic rd_output;
  logic rd_variant;
  logic wr_output_dp;
  assign rd_input = addr_phase && !hwrite && haddr == INPUT_IMAGE_OFFSET;
  assign rd_output = addr_phase && !hwrite && haddr == OUTPUT_IMAGE_OFFSET;
  assign rd_variant = addr_phase && !hwrite && haddr == VARIANT_OFFSET;
  assign wr_output_dp = dp_reg.valid && dp_reg.write && dp_reg.sel == SEL_OUTPUT;

  property p_state_byte;
    // Skip the edge still inside reset and the first one after it
    hresetn && $past(hresetn) |->
      image_reg.state == $past(channel_input_state & ~switch_off_reg);
  endproperty
  a_state_byte: assert property (p_state_byte) else $error("state byte mismatch"); // RL2

  property p_fault_byte;
    hresetn && $past(hresetn) |-> image_reg.fault ==
      $past((wire_break | short_circuit) & ~switch_off_reg);
  endproperty
  a_fault_byte: assert property (p_fault_byte) else $error("fault byte mismatch"); // RL3

  property p_switch_write;
    wr_output_dp |=> channel_switch_off == $past(hwdata[15:8]);
  endproperty
  a_switch_write: assert property (p_switch_write) else $error("switch-off not written"); // RL5

  property p_switch_hold;
    !wr_output_dp |=> $stable(channel_switch_off);
  endproperty
  a_switch_hold: assert property (p_switch_hold) else $error("switch-off changed"); // RL5

  property p_read_input;
    rd_input |=> hrdata == {16'h0000, $past(image_reg.fault), $past(image_reg.state)};
  endproperty
  a_read_input: assert property (p_read_input) else $error("input word order wrong"); // RL7

  property p_read_output;
    rd_output |=> hrdata[7:0] == 8'h00 && hrdata[31:16] == 16'h0000
      && hrdata[15:8] == channel_switch_off;
  endproperty
  a_read_output: assert property (p_read_output) else $error("output word wrong"); // RL1

  property p_read_variant;
    rd_variant |=> hrdata == {31'h0000_0000, VARIANT == VARIANT_THERMISTOR};
  endproperty
  a_read_variant: assert property (p_read_variant) else $error("variant word wrong"); // RL6

  property p_refresh;
    (channel_input_state != $past(channel_input_state)) && $stable(switch_off_reg)
      |=> image_reg.state != $past(image_reg.state) || $past(switch_off_reg) != 8'h00;
  endproperty
  a_refresh: assert property (p_refresh) else $error("image not refreshed"); // RL8

  c_read_input: cover property (rd_input ##1 hrdata[15:8] != 8'h00);
  c_write_output: cover property (wr_output_dp ##1 channel_switch_off != 8'h00);
  c_fault_seen: cover property (image_reg.fault != 8'h00);
  c_read_output: cover property (wr_output_dp ##0 rd_output);

endmodule

// *** test/ctrl_model.sv ***
// Controller model: AHB-Lite master exchanging the process image words
`timescale 1ns/1ns
module ctrl_model (
  input wire logic hclk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ----------------------------------------
  // Bus idle values
  // ----------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One single word transfer, address phase then data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Released write data no longer shows the last value
    hwdata <= ~d;
  endtask

  // Output word write: reserved low byte always zero
  task automatic write_off(input logic [7:0] b);
    logic [31:0] r;
    xfer(1'b1, 32'h0000_0004, {16'h0000, b, 8'h00}, r);
  endtask

  // Word read
  task automatic read_word(input logic [31:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'hFFFF_FFFF, r);
  endtask
endmodule

// *** test/tb_top.sv ***
// Testbench: process image reads, switch-off writes and reset behaviour
`timescale 1ns/1ns
module tb_top;
  import diag_image_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] channel_input_state = 8'h00;
  logic [7:0] wire_break = 8'h00;
  logic [7:0] short_circuit = 8'h00;
  logic [7:0] channel_switch_off;
  logic [31:0] hrdata_th;            // Read data of the thermistor variant
  logic [7:0] channel_switch_off_th; // Switch-off pattern of the thermistor variant
  int num_errors = 0;
  int cmp_count = 0;

  // Clock, 8 ns period
  always #4 hclk = ~hclk;

  octal_input_diag_image dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .channel_input_state(channel_input_state), .wire_break(wire_break),
    .short_circuit(short_circuit), .channel_switch_off(channel_switch_off));

  ctrl_model ctl (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // Thermistor variant on the same bus and field inputs
  octal_input_diag_image #(.VARIANT(VARIANT_THERMISTOR)) dut_th (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(), .hresp(),
    .hrdata(hrdata_th), .channel_input_state(channel_input_state), .wire_break(wire_break),
    .short_circuit(short_circuit), .channel_switch_off(channel_switch_off_th));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Field inputs change right after an edge
  task automatic set_field(input logic [7:0] s, input logic [7:0] w, input logic [7:0] c);
    @(posedge hclk);
    channel_input_state <= s;
    wire_break <= w;
    short_circuit <= c;
  endtask

  // Verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog against a hung bus
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({24'h0, channel_switch_off}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
    ctl.read_word(OUTPUT_IMAGE_OFFSET, r);
    chk(r, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    // Walking channel: state and wire break, then inverted state with short circuit
    for (int i = 0; i < 8; i++) begin
      set_field(8'h01 << i, 8'h01 << i, 8'h00);
      ctl.read_word(INPUT_IMAGE_OFFSET, r);
      chk(r, {16'h0000, 8'h01 << i, 8'h01 << i});
      set_field(~(8'h01 << i), 8'h00, 8'h80 >> i);
      ctl.read_word(INPUT_IMAGE_OFFSET, r);
      chk(r, {16'h0000, 8'h80 >> i, ~(8'h01 << i)});
      chk(hrdata_th, {16'h0000, 8'h80 >> i, ~(8'h01 << i)});
    end
    // Switch-off pattern, read back at once
    ctl.write_off(8'hA5);
    #1;
    chk({24'h0, channel_switch_off}, 32'h0000_00A5);
    chk({24'h0, channel_switch_off_th}, 32'h0000_00A5);
    ctl.read_word(OUTPUT_IMAGE_OFFSET, r);
    chk(r, 32'h0000_A500);
    set_field(8'hFF, 8'hFF, 8'h00);
    ctl.read_word(INPUT_IMAGE_OFFSET, r);
    chk(r, 32'h0000_5A5A);
    // All channels back on
    ctl.write_off(8'h00);
    #1;
    chk({24'h0, channel_switch_off}, 32'h0000_0000);
    ctl.read_word(INPUT_IMAGE_OFFSET, r);
    chk(r, 32'h0000_FFFF);
    // Variant word and an unmapped word
    ctl.read_word(VARIANT_OFFSET, r);
    chk(r, 32'h0000_0000);
    chk(hrdata_th, 32'h0000_0001);
    ctl.read_word(32'h0000_000C, r);
    chk(r, 32'h0000_0000);
    // Reset in mid-run clears the switch-off pattern
    ctl.write_off(8'h3C);
    #1;
    chk({24'h0, channel_switch_off}, 32'h0000_003C);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    chk({24'h0, channel_switch_off}, 32'h0000_0000);
    chk({31'h0, hreadyout}, 32'h0000_0001);
    @(posedge hclk);
    hresetn <= 1'b1;
    ctl.read_word(OUTPUT_IMAGE_OFFSET, r);
    chk(r, 32'h0000_0000);
    give_verdict();
  end
endmodule
